// ==== design/sgc_pkg.sv ====
package sgc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] OFS_EGR_RATE_LO   = 12'h0A8;
    localparam logic [11:0] OFS_EGR_RATE_HI   = 12'h0AA;
    localparam logic [11:0] OFS_GLOBAL_CTRL_A = 12'h0AC;
    localparam logic [11:0] OFS_GLOBAL_CTRL_B = 12'h0AE;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int RATE_UPPER_LSB   = 8;
    localparam int RATE_LOWER_LSB   = 0;
    localparam int RATE_WIDTH       = 7;
    localparam int EGR_ENABLE_BIT   = 7;
    localparam int QMAP_LSB         = 14;
    localparam int FLUSH_DYN_BIT    = 10;
    localparam int FLUSH_STATIC_BIT = 9;
    localparam int TAIL_TAG_BIT     = 8;
    localparam int PAUSE_LIM_LSB    = 0;
    localparam int INVALID_FWD_LSB  = 8;
    localparam int PVID_INS_LSB     = 0;

    // ****************************************************************
    // Reset values and writable masks
    // ****************************************************************
    localparam logic [6:0]  RATE_RST       = 7'h00;
    localparam logic [1:0]  QMAP_RST       = 2'h2;
    localparam logic [7:0]  PAUSE_LIM_RST  = 8'h00;
    localparam logic [2:0]  INVALID_FWD_RST = 3'h0;
    localparam logic [5:0]  PVID_INS_RST   = 6'h00;
    localparam logic [15:0] RATE_WORD_MASK = 16'h7F7F;
    localparam logic [15:0] CTRL_A_MASK    = 16'hC7FF;
    localparam logic [15:0] CTRL_B_MASK    = 16'h073F;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int PAUSE_UNIT_MS = 160;
    localparam int CLK_HZ        = 40000000;
    localparam int FLUSH_CYCLES  = 1024;

endpackage

// ==== design/sgc_flush_seq.sv ====
`timescale 1ns/1ps
`default_nettype none

module sgc_flush_seq #(
    parameter int CYCLES = sgc_pkg::FLUSH_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic start,
    output logic      busy
);
    typedef enum logic [0:0] {
        SGC_IDLE = 1'b0,
        SGC_RUN  = 1'b1
    } sgc_fstate_t;

    typedef struct packed {
        sgc_fstate_t  st;
        logic [15:0]  cnt;
    } sgc_fseq_t;

    sgc_fseq_t s_q;
    sgc_fseq_t s_d;

    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            SGC_IDLE: begin
                if (start) begin
                    s_d.st  = SGC_RUN;
                    s_d.cnt = 16'(CYCLES - 1);
                end
            end
            SGC_RUN: begin
                if (s_q.cnt == 16'h0000) begin
                    s_d.st = SGC_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '{st: SGC_IDLE, cnt: 16'h0000};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.st == SGC_RUN);
endmodule

`default_nettype wire

// ==== design/sgc_switch_global_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module sgc_switch_global_ctrl #(
    parameter int FLUSH_CYCLES = sgc_pkg::FLUSH_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [11:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [1:0]  regByteEn,
    input  wire logic [15:0] regWrData,
    output logic [15:0]      regRdData,
    output logic             regRdValid,
    input  wire logic        twoQueueMode,
    output logic [6:0]       shapeCodeP0,
    output logic [6:0]       shapeCodeP1,
    output logic [6:0]       shapeCodeP2,
    output logic [6:0]       shapeCodeP3,
    output logic [3:0]       shapeActive,
    output logic [1:0]       queueMap,
    output logic             queueMapValid,
    output logic             flushDynamic,
    output logic             flushStaticEn,
    output logic             tailTagEn,
    output logic             pauseLimitEn,
    output logic [7:0]       pauseLimitCount,
    output logic [2:0]       invalidVidFwd,
    output logic [5:0]       pvidInsertEn
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0] rateLo;
        logic [15:0] rateHi;
        logic [15:0] ctrlA;
        logic [15:0] ctrlB;
        logic [15:0] rdData;
        logic        rdValid;
        logic        flushReq;
        logic [6:0]  code0;
        logic [6:0]  code1;
        logic [6:0]  code2;
        logic [6:0]  code3;
        logic [3:0]  active;
        logic [1:0]  qmap;
        logic        qmapValid;
        logic        flushBit;
        logic        fStatic;
        logic        tTag;
        logic        pEn;
        logic [7:0]  pCnt;
        logic [2:0]  invFwd;
        logic [5:0]  pvid;
    } sgc_state_t;

    sgc_state_t st_q;
    sgc_state_t st_d;
    logic       flushBusy;

    // Byte-enabled merge of a write into a register, masked to writable bits
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wr,
                                          input logic [1:0] be, input logic [15:0] msk);
        logic [15:0] lane;
        lane = {{8{be[1]}}, {8{be[0]}}};
        merge = ((old & ~lane) | (wr & lane)) & msk;
    endfunction

    // Zero code means no limit, so that priority is not shaped
    function automatic logic gateCode(input logic en, input logic use_q, input logic [6:0] c);
        gateCode = en & use_q & (c != sgc_pkg::RATE_RST);
    endfunction

    sgc_flush_seq #(
        .CYCLES(FLUSH_CYCLES)
    ) i_sgc_flush_seq (
        .core_clk(core_clk),
        .resetn  (resetn),
        .start   (st_q.flushReq),
        .busy    (flushBusy)
    );

    // ****************************************************************
    // Register access and outputs
    // ****************************************************************
    always_comb begin
        logic        egrEn;
        logic        flushDone;
        logic [6:0]  c0;
        logic [6:0]  c1;
        logic [6:0]  c2;
        logic [6:0]  c3;
        egrEn     = 1'b0;
        c0        = 7'h00;
        c1        = 7'h00;
        c2        = 7'h00;
        c3        = 7'h00;
        // Self-clear once the sequencer has gone busy and then idle again
        flushDone = st_q.ctrlA[sgc_pkg::FLUSH_DYN_BIT] && !st_q.flushReq && !flushBusy;
        st_d      = st_q;
        st_d.rdValid  = 1'b0;
        st_d.flushReq = 1'b0;

        if (regWrite) begin
            unique case (regAddr)
                sgc_pkg::OFS_EGR_RATE_LO: begin
                    st_d.rateLo = merge(st_q.rateLo, regWrData, regByteEn, 16'hFFFF);
                    st_d.rateLo[15] = 1'b0;
                end
                sgc_pkg::OFS_EGR_RATE_HI: begin
                    st_d.rateHi = merge(st_q.rateHi, regWrData, regByteEn,
                                        sgc_pkg::RATE_WORD_MASK);
                end
                sgc_pkg::OFS_GLOBAL_CTRL_A: begin
                    st_d.ctrlA = merge(st_q.ctrlA, regWrData, regByteEn, sgc_pkg::CTRL_A_MASK);
                    // A flush request cannot be withdrawn by writing zero mid-flush
                    if (st_q.ctrlA[sgc_pkg::FLUSH_DYN_BIT] && !flushDone) begin
                        st_d.ctrlA[sgc_pkg::FLUSH_DYN_BIT] = 1'b1;
                    end else if (regByteEn[1] && regWrData[sgc_pkg::FLUSH_DYN_BIT]) begin
                        st_d.flushReq = 1'b1;
                    end
                end
                sgc_pkg::OFS_GLOBAL_CTRL_B: begin
                    st_d.ctrlB = merge(st_q.ctrlB, regWrData, regByteEn,
                                       sgc_pkg::CTRL_B_MASK);
                end
                default: begin
                end
            endcase
        end

        // A new request in the finishing cycle wins over the self-clear
        if (flushDone && !st_d.flushReq) begin
            st_d.ctrlA[sgc_pkg::FLUSH_DYN_BIT] = 1'b0;
        end

        if (regRead) begin
            st_d.rdValid = 1'b1;
            unique case (regAddr)
                sgc_pkg::OFS_EGR_RATE_LO:   st_d.rdData = st_q.rateLo;
                sgc_pkg::OFS_EGR_RATE_HI:   st_d.rdData = st_q.rateHi;
                sgc_pkg::OFS_GLOBAL_CTRL_A: st_d.rdData = st_q.ctrlA;
                sgc_pkg::OFS_GLOBAL_CTRL_B: st_d.rdData = st_q.ctrlB;
                default:                    st_d.rdData = 16'h0000;
            endcase
        end

        // Decoded configuration, derived from the registers as they stand
        egrEn = st_q.rateLo[sgc_pkg::EGR_ENABLE_BIT];
        c0 = st_q.rateLo[sgc_pkg::RATE_LOWER_LSB +: sgc_pkg::RATE_WIDTH];
        c1 = st_q.rateLo[sgc_pkg::RATE_UPPER_LSB +: sgc_pkg::RATE_WIDTH];
        c2 = st_q.rateHi[sgc_pkg::RATE_LOWER_LSB +: sgc_pkg::RATE_WIDTH];
        c3 = st_q.rateHi[sgc_pkg::RATE_UPPER_LSB +: sgc_pkg::RATE_WIDTH];
        st_d.code0 = c0;
        st_d.code1 = c1;
        st_d.code2 = c2;
        st_d.code3 = c3;
        st_d.active[0] = gateCode(egrEn, 1'b1, c0);
        st_d.active[1] = gateCode(egrEn, twoQueueMode, c1);
        // Priorities 2 and 3 are never shaped in one- or two-queue operation
        st_d.active[2] = gateCode(egrEn, 1'b0, c2);
        st_d.active[3] = gateCode(egrEn, 1'b0, c3);
        st_d.qmap      = st_q.ctrlA[sgc_pkg::QMAP_LSB +: 2];
        st_d.qmapValid = st_q.ctrlA[sgc_pkg::QMAP_LSB];
        st_d.flushBit  = st_q.ctrlA[sgc_pkg::FLUSH_DYN_BIT];
        st_d.fStatic   = st_q.ctrlA[sgc_pkg::FLUSH_STATIC_BIT];
        st_d.tTag      = st_q.ctrlA[sgc_pkg::TAIL_TAG_BIT];
        st_d.pCnt      = st_q.ctrlA[sgc_pkg::PAUSE_LIM_LSB +: 8];
        st_d.pEn       = (st_q.ctrlA[sgc_pkg::PAUSE_LIM_LSB +: 8]
                          != sgc_pkg::PAUSE_LIM_RST);
        st_d.invFwd    = st_q.ctrlB[sgc_pkg::INVALID_FWD_LSB +: 3];
        st_d.pvid      = st_q.ctrlB[sgc_pkg::PVID_INS_LSB +: 6];
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_q       <= '0;
            st_q.ctrlA <= {sgc_pkg::QMAP_RST, 14'h0000};
            st_q.qmap  <= sgc_pkg::QMAP_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs, all straight from state flops
    // ****************************************************************
    assign regRdData       = st_q.rdData;
    assign regRdValid      = st_q.rdValid;
    assign shapeCodeP0     = st_q.code0;
    assign shapeCodeP1     = st_q.code1;
    assign shapeCodeP2     = st_q.code2;
    assign shapeCodeP3     = st_q.code3;
    assign shapeActive     = st_q.active;
    assign queueMap        = st_q.qmap;
    assign queueMapValid   = st_q.qmapValid;
    assign flushDynamic    = st_q.flushBit;
    assign flushStaticEn   = st_q.fStatic;
    assign tailTagEn       = st_q.tTag;
    assign pauseLimitEn    = st_q.pEn;
    assign pauseLimitCount = st_q.pCnt;
    assign invalidVidFwd   = st_q.invFwd;
    assign pvidInsertEn    = st_q.pvid;

endmodule

`default_nettype wire

// ==== tb/sgc_switch_global_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checks for the global control register block
// ****************************************************************
module sgc_switch_global_ctrl_properties #(
    parameter int FLUSH_CYCLES = 8
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [11:0] regAddr,
    input wire logic        regWrite,
    input wire logic [1:0]  regByteEn,
    input wire logic [15:0] regWrData,
    input wire logic        twoQueueMode,
    input wire logic [6:0]  shapeCodeP0,
    input wire logic [6:0]  shapeCodeP2,
    input wire logic [6:0]  shapeCodeP3,
    input wire logic [3:0]  shapeActive,
    input wire logic [1:0]  queueMap,
    input wire logic        queueMapValid,
    input wire logic        flushDynamic,
    input wire logic        flushStaticEn,
    input wire logic        tailTagEn,
    input wire logic        pauseLimitEn,
    input wire logic [7:0]  pauseLimitCount,
    input wire logic [2:0]  invalidVidFwd,
    input wire logic [5:0]  pvidInsertEn
);
    logic wrHi;
    logic wrA;
    logic wrB;
    int   flushLen_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    assign wrHi = regWrite && regAddr == sgc_pkg::OFS_EGR_RATE_HI && regByteEn == 2'h3;
    assign wrA  = regWrite && regAddr == sgc_pkg::OFS_GLOBAL_CTRL_A && regByteEn[1];
    assign wrB  = regWrite && regAddr == sgc_pkg::OFS_GLOBAL_CTRL_B && regByteEn == 2'h3;
    // Cycles that the flush flag has stood since the last control A write with the flush bit set
    // A request that chains onto the end of a flush restarts the count
    always_ff @(posedge core_clk) begin
        if (!resetn || !flushDynamic || (wrA && regWrData[10])) begin
            flushLen_q <= 0;
        end else if (flushLen_q < FLUSH_CYCLES + 8) begin
            flushLen_q <= flushLen_q + 1;
        end
    end
    hi_code_p3_a: assert property (wrHi |-> ##2 shapeCodeP3 == $past(regWrData[14:8], 2))
        else $error("priority 3 code wrong");
    hi_code_p2_a: assert property (wrHi |-> ##2 shapeCodeP2 == $past(regWrData[6:0], 2))
        else $error("priority 2 code wrong");
    zero_code_idle_a: assert property (shapeActive[0] |-> shapeCodeP0 != 7'h00)
        else $error("zero code limited");
    single_queue_a: assert property (!$past(twoQueueMode) |-> !shapeActive[1])
        else $error("priority 1 limit in single queue");
    upper_prio_off_a: assert property (shapeActive[3:2] == 2'h0)
        else $error("priority 2 or 3 limit active");
    map_valid_a: assert property (queueMapValid == queueMap[0])
        else $error("queue map validity wrong");
    flush_start_a: assert property (wrA && regWrData[10] |-> ##2 flushDynamic)
        else $error("flush not started");
    flush_end_a: assert property (flushLen_q <= FLUSH_CYCLES + 4)
        else $error("flush never ends");
    ctrl_a_bits_a: assert property (wrA |-> ##2 {flushStaticEn, tailTagEn} == $past(regWrData[9:8], 2))
        else $error("static flush or tail tag wrong");
    pause_enable_a: assert property (pauseLimitEn == (pauseLimitCount != 8'h00))
        else $error("pause limit enable wrong");
    vid_fwd_a: assert property (wrB |-> ##2 invalidVidFwd == $past(regWrData[10:8], 2))
        else $error("invalid VID mask wrong");
    pvid_ins_a: assert property (wrB |-> ##2 pvidInsertEn == $past(regWrData[5:0], 2))
        else $error("tag insert enables wrong");
endmodule
bind sgc_switch_global_ctrl sgc_switch_global_ctrl_properties #(.FLUSH_CYCLES(FLUSH_CYCLES)) i_props (
    .core_clk, .resetn, .regAddr, .regWrite, .regByteEn, .regWrData, .twoQueueMode,
    .shapeCodeP0, .shapeCodeP2, .shapeCodeP3, .shapeActive, .queueMap, .queueMapValid,
    .flushDynamic, .flushStaticEn, .tailTagEn, .pauseLimitEn, .pauseLimitCount,
    .invalidVidFwd, .pvidInsertEn);
`default_nettype wire

// ==== tb/sgc_switch_global_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module sgc_switch_global_ctrl_bench;
    typedef struct packed {
        logic [11:0] a;
        logic [1:0]  be;
        logic [15:0] wd;
        logic [15:0] rd;
    } sgc_row_t;
    // Reserved bits and an unmapped word must read back as zero
    localparam sgc_row_t ROWS [7] = '{'{12'h0AA, 2'h3, 16'hFFFF, 16'h7F7F},
        '{12'h0AA, 2'h2, 16'h0305, 16'h037F}, '{12'h0AE, 2'h3, 16'hFFFF, 16'h073F},
        '{12'h0AE, 2'h1, 16'h0015, 16'h0715}, '{12'h0AC, 2'h3, 16'hFBFF, 16'hC3FF},
        '{12'h0B0, 2'h3, 16'hFFFF, 16'h0000}, '{12'h0A8, 2'h3, 16'hFFFF, 16'h7FFF}};
    logic        core_clk, resetn, regWrite, regRead, regRdValid, twoQueueMode;
    logic [11:0] regAddr;
    logic [1:0]  regByteEn, queueMap;
    logic [15:0] regWrData, regRdData, rv;
    logic [6:0]  shapeCodeP0, shapeCodeP1, shapeCodeP2, shapeCodeP3;
    logic [3:0]  shapeActive;
    logic        queueMapValid, flushDynamic, flushStaticEn, tailTagEn, pauseLimitEn;
    logic [7:0]  pauseLimitCount;
    logic [2:0]  invalidVidFwd;
    logic [5:0]  pvidInsertEn;
    int          mismatches = 0;
    int          num_checks = 0;
    // Short flush keeps the run brief
    sgc_switch_global_ctrl #(.FLUSH_CYCLES(8)) i_sgc_switch_global_ctrl (.core_clk, .resetn,
        .regAddr, .regWrite, .regRead, .regByteEn, .regWrData, .regRdData, .regRdValid,
        .twoQueueMode, .shapeCodeP0, .shapeCodeP1, .shapeCodeP2, .shapeCodeP3, .shapeActive,
        .queueMap, .queueMapValid, .flushDynamic, .flushStaticEn, .tailTagEn, .pauseLimitEn,
        .pauseLimitCount, .invalidVidFwd, .pvidInsertEn);
    // ****************************************************************
    // Bus tasks and comparison
    // ****************************************************************
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge core_clk);
        regAddr = a;
        regByteEn = be;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge core_clk);
        regWrite = 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [15:0] e);
        @(negedge core_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge core_clk);
        regRead = 1'b0;
        chk("regRdValid", 16'h0001, {15'h0000, regRdValid});
        chk("regRdData", e, regRdData);
    endtask
    // Decoded outputs land one edge after the write edge
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #75000;
        mismatches++;
        summarize();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {resetn, regWrite, regRead, twoQueueMode, regAddr, regByteEn, regWrData} = '0;
        repeat (5) @(negedge core_clk);
        chk("queueMap", 16'h0002, {14'h0000, queueMap});
        resetn = 1'b1;
        rchk(sgc_pkg::OFS_GLOBAL_CTRL_A, 16'h8000);
        rchk(sgc_pkg::OFS_EGR_RATE_HI, 16'h0000);
        rchk(sgc_pkg::OFS_GLOBAL_CTRL_B, 16'h0000);
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].be, ROWS[i].wd);
            rchk(ROWS[i].a, ROWS[i].rd);
        end
        wr(sgc_pkg::OFS_EGR_RATE_LO, 2'h3, 16'h0285);
        settle();
        chk("shapeActive", 16'h0001, {12'h000, shapeActive});
        @(negedge core_clk);
        twoQueueMode = 1'b1;
        settle();
        chk("shapeActive", 16'h0003, {12'h000, shapeActive});
        wr(sgc_pkg::OFS_EGR_RATE_LO, 2'h3, 16'h0205);
        settle();
        chk("shapeActive", 16'h0000, {12'h000, shapeActive});
        wr(sgc_pkg::OFS_EGR_RATE_LO, 2'h3, 16'h0280);
        settle();
        chk("shapeActive", 16'h0002, {12'h000, shapeActive});
        chk("shapeCodes", 16'h0200, {1'b0, shapeCodeP1, 1'b0, shapeCodeP0});
        wr(sgc_pkg::OFS_EGR_RATE_HI, 2'h3, 16'h0305);
        settle();
        chk("shapeCodes", 16'h0305, {1'b0, shapeCodeP3, 1'b0, shapeCodeP2});
        wr(sgc_pkg::OFS_GLOBAL_CTRL_A, 2'h3, 16'h81FF);
        settle();
        chk("ctrlA", 16'h23FF, {2'h0, queueMap, queueMapValid, flushStaticEn, tailTagEn,
            pauseLimitEn, pauseLimitCount});
        wr(sgc_pkg::OFS_GLOBAL_CTRL_A, 2'h3, 16'h4200);
        settle();
        chk("ctrlA", 16'h1C00, {2'h0, queueMap, queueMapValid, flushStaticEn, tailTagEn,
            pauseLimitEn, pauseLimitCount});
        wr(sgc_pkg::OFS_GLOBAL_CTRL_A, 2'h3, 16'hC101);
        settle();
        chk("ctrlA", 16'h3B01, {2'h0, queueMap, queueMapValid, flushStaticEn, tailTagEn,
            pauseLimitEn, pauseLimitCount});
        wr(sgc_pkg::OFS_GLOBAL_CTRL_A, 2'h3, 16'h0400);
        settle();
        chk("flushDynamic", 16'h0001, {15'h0000, flushDynamic});
        wr(sgc_pkg::OFS_GLOBAL_CTRL_A, 2'h3, 16'h0000);
        rchk(sgc_pkg::OFS_GLOBAL_CTRL_A, 16'h0400);
        for (int k = 0; k < 40 && flushDynamic; k++)
            @(negedge core_clk);
        chk("flushDynamic", 16'h0000, {15'h0000, flushDynamic});
        rchk(sgc_pkg::OFS_GLOBAL_CTRL_A, 16'h0000);
        @(negedge core_clk);
        resetn = 1'b0;
        @(negedge core_clk);
        resetn = 1'b1;
        chk("shapeActive", 16'h0000, {12'h000, shapeActive});
        rchk(sgc_pkg::OFS_GLOBAL_CTRL_B, 16'h0000);
        rchk(sgc_pkg::OFS_GLOBAL_CTRL_A, 16'h8000);
        summarize();
    end
endmodule
`default_nettype wire
